// >>> src/ssp_pkg.sv
/*
  constants and types shared by the sync serial port pin logic.
  assumes a 16-bit serial word and a master clock equal to CLK.
*/
`default_nettype none
package ssp_pkg;
  // ---------------------------------------------------------------
  // word framing
  // ---------------------------------------------------------------
  localparam int WORD_BITS = 16;                    // bits per serial word
  localparam int CNT_W = 4;                         // bit counter width
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;     // counter reset value
  localparam logic [CNT_W-1:0] CNT_LAST = 4'hF;     // index of last bit
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;      // counter step
  localparam logic [WORD_BITS-1:0] WORD_ZERO = 16'h0000; // idle word
  localparam int MSB = WORD_BITS - 1;               // first bit sent
  // ---------------------------------------------------------------
  // pin levels and control encodings
  // ---------------------------------------------------------------
  localparam logic FS_IDLE = 1'b1;                  // frame sync rests high
  localparam logic FS_ACTIVE = 1'b0;                // frame sync pulse level
  localparam logic SRC_INTERNAL = 1'b1;             // bit clock made here
  localparam logic DIR_OUTPUT = 1'b1;               // frame sync driven here
  localparam int SYNC_MAIN_W = 5;                   // pin levels and receive toggle synced into CLK
  localparam int SYNC_LINK_W = 2;                   // levels synced into link
  // ---------------------------------------------------------------
  // transmit sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SHIFT = 2'b10
  } tx_state_t;
endpackage
`default_nettype wire

// >>> src/ssp_sync2.sv
/*
  two flip-flop synchroniser for a bundle of independent levels.
  assumes each bit is a level that changes slowly against clk.
*/
`default_nettype none
module ssp_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q; // first stage, read only by second
  // ---------------------------------------------------------------
  // two stages, frozen while ce is low
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (ce) begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// >>> src/ssp_pins.sv
/*
  sync serial port pin logic: transmit bit clock source, frame sync
  direction, transmit and receive shift registers, output disable.
  assumes CLK is the master clock, RX_BIT_CLOCK is supplied by the peer,
  and control bits come from a control register outside this block.
*/
// Summary of operation
// - select 0: transmit bit clock is input
// - select 1: drive bit clock at half master
// - transmit bit clock is input after reset
// - shift transmit register out on bit clock
// - frame sync falling edge starts transmission
// - frame sync input unless direction bit set
// - receive frame sync falling edge starts reception
// - receive data pin loads receive shift register
// - receive clock level readable as status bit
// - disable floats data, frame sync, bit clock
// - disable when test reset low, emulator_pin_zero high, pin low
`default_nettype none
module ssp_pins
  import ssp_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic CLOCK_SOURCE_SELECT,
  input wire logic FRAME_SYNC_DIRECTION,
  input wire logic [WORD_BITS-1:0] TX_DATA,
  input wire logic TX_VALID,
  output logic TX_READY,
  input wire logic TX_BIT_CLOCK_IN,
  output logic TX_BIT_CLOCK_OUT,
  output logic TX_BIT_CLOCK_OE,
  input wire logic TX_FRAME_SYNC_IN,
  output logic TX_FRAME_SYNC_OUT,
  output logic TX_FRAME_SYNC_OE,
  output logic TX_SERIAL_OUT,
  output logic TX_SERIAL_OE,
  input wire logic RX_BIT_CLOCK,
  input wire logic RX_FRAME_SYNC,
  input wire logic RX_SERIAL_IN,
  output logic [WORD_BITS-1:0] RX_DATA,
  output logic RX_VALID,
  output logic RX_CLOCK_LEVEL,
  input wire logic TEST_RESET,
  input wire logic EMULATOR_PIN_ZERO,
  input wire logic OUTPUT_DISABLE_N
);
  // ---------------------------------------------------------------
  // pin synchronisers into CLK
  // ---------------------------------------------------------------
  logic [SYNC_MAIN_W-1:0] main_raw; // raw pins and crossing toggle
  logic [SYNC_MAIN_W-1:0] main_s; // synchronised copies
  logic rx_toggle_q; // flips once per received word (link domain)
  assign main_raw = {TX_BIT_CLOCK_IN, TX_FRAME_SYNC_IN, rx_toggle_q, RX_BIT_CLOCK,
                     (~TEST_RESET & EMULATOR_PIN_ZERO & ~OUTPUT_DISABLE_N)};
  ssp_sync2 #(.WIDTH(SYNC_MAIN_W)) u_sync_main (
    .clk(CLK),
    .ce(CE),
    .async_in(main_raw),
    .sync_out(main_s)
  );
  wire ext_clk_s = main_s[4]; // external transmit bit clock level
  wire ext_fs_s = main_s[3]; // external transmit frame sync level
  wire rx_tog_s = main_s[2]; // receive word toggle
  wire rx_clk_s = main_s[1]; // receive bit clock level
  wire off_s = main_s[0]; // output disable condition

  // ---------------------------------------------------------------
  // transmit bit clock source
  // ---------------------------------------------------------------
  logic div_q; // internal bit clock, half of CLK
  logic ext_clk_prev_q; // previous external clock level
  logic ext_fs_prev_q; // frame sync level at previous bit tick
  wire internal_src = (CLOCK_SOURCE_SELECT == SRC_INTERNAL);
  wire int_tick = internal_src & ~div_q; // bit clock about to rise
  wire ext_tick = ~internal_src & ext_clk_s & ~ext_clk_prev_q;
  wire bit_tick = CE & (int_tick | ext_tick);

  // divider toggles every master clock, giving half the frequency
  always_ff @(posedge CLK) begin
    if (RST) begin
      div_q <= 1'b0;
      ext_clk_prev_q <= 1'b0;
    end else if (CE) begin
      div_q <= internal_src ? ~div_q : 1'b0;
      ext_clk_prev_q <= ext_clk_s;
    end
  end

  // ---------------------------------------------------------------
  // transmit sequencer
  // ---------------------------------------------------------------
  tx_state_t tx_state_q, tx_state_d; // sequencer state
  logic [WORD_BITS-1:0] tx_shift_reg_q, tx_shift_reg_d; // transmit shift register
  logic [CNT_W-1:0] tx_cnt_q, tx_cnt_d; // bits sent in this word
  logic fs_out_q, fs_out_d; // driven frame sync level
  logic fs_dir_q; // frame sync direction in use
  wire fs_master = (FRAME_SYNC_DIRECTION == DIR_OUTPUT);
  wire ext_fs_fall = ext_fs_prev_q & ~ext_fs_s;
  wire tx_idle = (tx_state_q == TX_IDLE);
  wire tx_start = bit_tick & tx_idle & (fs_master ? TX_VALID : ext_fs_fall);
  wire tx_take = tx_start & TX_VALID; // word accepted
  assign TX_READY = bit_tick & tx_idle & (fs_master | ext_fs_fall);

  // next state: load on start, then one bit per tick msb first
  always_comb begin
    tx_state_d = tx_state_q;
    tx_shift_reg_d = tx_shift_reg_q;
    tx_cnt_d = tx_cnt_q;
    fs_out_d = fs_out_q;
    if (bit_tick) begin
      fs_out_d = FS_IDLE; // pulse lasts one bit period
      case (tx_state_q)
        TX_IDLE: begin
          if (tx_start) begin
            tx_shift_reg_d = tx_take ? TX_DATA : WORD_ZERO; // underrun sends zeros
            tx_cnt_d = CNT_ZERO;
            tx_state_d = TX_SHIFT;
            if (fs_master) begin
              fs_out_d = FS_ACTIVE;
            end
          end
        end
        TX_SHIFT: begin
          tx_shift_reg_d = {tx_shift_reg_q[MSB-1:0], 1'b0};
          tx_cnt_d = tx_cnt_q + CNT_ONE;
          if (tx_cnt_q == CNT_LAST) begin
            tx_state_d = TX_IDLE;
          end
        end
        default: begin
          tx_state_d = TX_IDLE;
        end
      endcase
    end
  end

  // transmit registers
  always_ff @(posedge CLK) begin
    if (RST) begin
      tx_state_q <= TX_IDLE;
      tx_shift_reg_q <= WORD_ZERO;
      tx_cnt_q <= CNT_ZERO;
      fs_out_q <= FS_IDLE;
      ext_fs_prev_q <= FS_IDLE;
      fs_dir_q <= 1'b0;
    end else if (CE) begin
      tx_state_q <= tx_state_d;
      tx_shift_reg_q <= tx_shift_reg_d;
      tx_cnt_q <= tx_cnt_d;
      fs_out_q <= fs_out_d;
      fs_dir_q <= fs_master;
      if (bit_tick) begin
        ext_fs_prev_q <= ext_fs_s;
      end
    end
  end

  // ---------------------------------------------------------------
  // transmit pins and output disable
  // ---------------------------------------------------------------
  logic clk_oe_q; // bit clock driven, off at reset
  always_ff @(posedge CLK) begin
    if (RST) begin
      clk_oe_q <= 1'b0;
    end else if (CE) begin
      clk_oe_q <= internal_src;
    end
  end
  assign TX_BIT_CLOCK_OUT = div_q;
  assign TX_BIT_CLOCK_OE = clk_oe_q & ~off_s;
  assign TX_FRAME_SYNC_OUT = fs_out_q;
  assign TX_FRAME_SYNC_OE = fs_dir_q & ~off_s;
  assign TX_SERIAL_OUT = tx_shift_reg_q[MSB];
  assign TX_SERIAL_OE = ~off_s;

  // ---------------------------------------------------------------
  // receive side on the peer's bit clock
  // ---------------------------------------------------------------
  logic [SYNC_LINK_W-1:0] link_s; // reset and enable in link domain
  ssp_sync2 #(.WIDTH(SYNC_LINK_W)) u_sync_link (
    .clk(RX_BIT_CLOCK),
    .ce(1'b1),
    .async_in({RST, CE}),
    .sync_out(link_s)
  );
  wire link_rst = link_s[1];
  wire link_ce = link_s[0];
  logic [WORD_BITS-1:0] rx_shift_reg_q; // receive shift register
  logic [WORD_BITS-1:0] rx_word_q; // last complete word, held
  logic [CNT_W-1:0] rx_cnt_q; // bits received
  logic rx_busy_q; // word in progress
  logic rx_fs_prev_q; // frame sync at previous edge
  wire rx_fs_fall = rx_fs_prev_q & ~RX_FRAME_SYNC;
  wire rx_shifting = rx_busy_q | rx_fs_fall;
  wire [WORD_BITS-1:0] rx_next = {rx_shift_reg_q[MSB-1:0], RX_SERIAL_IN};

  // samples one bit per rising edge from the frame sync fall on
  always_ff @(posedge RX_BIT_CLOCK) begin
    if (link_rst) begin
      rx_shift_reg_q <= WORD_ZERO;
      rx_word_q <= WORD_ZERO;
      rx_cnt_q <= CNT_ZERO;
      rx_busy_q <= 1'b0;
      rx_fs_prev_q <= FS_IDLE;
      rx_toggle_q <= 1'b0;
    end else if (link_ce) begin
      rx_fs_prev_q <= RX_FRAME_SYNC;
      if (rx_shifting) begin
        rx_shift_reg_q <= rx_next;
        rx_cnt_q <= rx_busy_q ? rx_cnt_q + CNT_ONE : CNT_ONE;
        rx_busy_q <= 1'b1;
        if (rx_busy_q && rx_cnt_q == CNT_LAST) begin
          rx_word_q <= rx_next;
          rx_toggle_q <= ~rx_toggle_q;
          rx_busy_q <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // receive word hand-off and clock level status
  // ---------------------------------------------------------------
  logic rx_tog_prev_q; // previous synced toggle
  always_ff @(posedge CLK) begin
    if (RST) begin
      rx_tog_prev_q <= 1'b0;
      RX_DATA <= WORD_ZERO;
      RX_VALID <= 1'b0;
      RX_CLOCK_LEVEL <= 1'b0;
    end else if (CE) begin
      rx_tog_prev_q <= rx_tog_s;
      RX_VALID <= rx_tog_s ^ rx_tog_prev_q;
      RX_CLOCK_LEVEL <= rx_clk_s;
      if (rx_tog_s ^ rx_tog_prev_q) begin
        RX_DATA <= rx_word_q; // stable for a whole word time
      end
    end
  end
endmodule
`default_nettype wire

// >>> test/ssp_pins_asserts.sv
/* concurrent checks on the sync serial port pins.
   sees only the top ports of ssp_pins; the bind stands at the foot. */
`default_nettype none
module ssp_pins_asserts
  import ssp_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic CLOCK_SOURCE_SELECT,
  input wire logic FRAME_SYNC_DIRECTION,
  input wire logic [WORD_BITS-1:0] TX_DATA,
  input wire logic TX_VALID,
  input wire logic TX_READY,
  input wire logic TX_BIT_CLOCK_OUT,
  input wire logic TX_BIT_CLOCK_OE,
  input wire logic TX_FRAME_SYNC_OUT,
  input wire logic TX_FRAME_SYNC_OE,
  input wire logic TX_SERIAL_OUT,
  input wire logic TX_SERIAL_OE,
  input wire logic RX_BIT_CLOCK,
  input wire logic RX_CLOCK_LEVEL,
  input wire logic TEST_RESET,
  input wire logic EMULATOR_PIN_ZERO,
  input wire logic OUTPUT_DISABLE_N
);
  // ---------------------------------------------------------------
  // helper logic: disable term and the word last taken
  // ---------------------------------------------------------------
  wire logic off_c = ~TEST_RESET & EMULATOR_PIN_ZERO & ~OUTPUT_DISABLE_N;
  wire logic take_c = TX_VALID & TX_READY;
  logic [WORD_BITS-1:0] word_q;
  always_ff @(posedge CLK) begin
    if (take_c) begin
      word_q <= TX_DATA;
    end
  end
  default clocking dclk @(posedge CLK); endclocking
  default disable iff (RST);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  rst_state_a: assert property ($fell(RST) |-> !TX_BIT_CLOCK_OE && !TX_FRAME_SYNC_OE && TX_FRAME_SYNC_OUT)
    else $error("pin state after reset wrong");
  ext_src_a: assert property (!CLOCK_SOURCE_SELECT [*3] |-> !TX_BIT_CLOCK_OE)
    else $error("bit clock driven while external");
  half_rate_a: assert property (TX_BIT_CLOCK_OE && $past(TX_BIT_CLOCK_OE) |-> $changed(TX_BIT_CLOCK_OUT))
    else $error("bit clock not at half rate");
  fs_input_a: assert property (!FRAME_SYNC_DIRECTION [*3] |-> !TX_FRAME_SYNC_OE)
    else $error("frame sync driven while input");
  off_float_a: assert property (off_c [*4] |-> !TX_SERIAL_OE && !TX_FRAME_SYNC_OE && !TX_BIT_CLOCK_OE)
    else $error("outputs driven while disabled");
  on_drive_a: assert property (!off_c [*4] |-> TX_SERIAL_OE)
    else $error("data output floats while enabled");
  tx_start_a: assert property (take_c && TX_FRAME_SYNC_OE && TX_BIT_CLOCK_OE |=>
    (!TX_FRAME_SYNC_OUT && TX_SERIAL_OUT == word_q[MSB]) ##2 (TX_FRAME_SYNC_OUT && TX_SERIAL_OUT == word_q[MSB-1]))
    else $error("frame start or first bits wrong");
  tx_quiet_a: assert property (take_c |=> !TX_READY [*8])
    else $error("word taken while shifting");
  rx_level_a: assert property (!RX_BIT_CLOCK [*4] |-> !RX_CLOCK_LEVEL)
    else $error("clock level status stale");
  cover property (take_c && TX_BIT_CLOCK_OE);
  cover property (off_c [*4]);
  cover property ($fell(RX_CLOCK_LEVEL));
endmodule
bind ssp_pins ssp_pins_asserts u_chk (.CLK, .RST, .CLOCK_SOURCE_SELECT, .FRAME_SYNC_DIRECTION, .TX_DATA, .TX_VALID,
  .TX_READY, .TX_BIT_CLOCK_OUT, .TX_BIT_CLOCK_OE, .TX_FRAME_SYNC_OUT, .TX_FRAME_SYNC_OE, .TX_SERIAL_OUT,
  .TX_SERIAL_OE, .RX_BIT_CLOCK, .RX_CLOCK_LEVEL, .TEST_RESET, .EMULATOR_PIN_ZERO, .OUTPUT_DISABLE_N);
`default_nettype wire

// >>> test/ssp_peer.sv
/* serial peer model: makes the receive bit clock and sends words.
   assumes one rise of send per word, with the clock enabled. */
`default_nettype none
module ssp_peer
  import ssp_pkg::*;
(
  input wire logic clk_en,
  input wire logic send,
  input wire logic [WORD_BITS-1:0] word,
  output logic bclk,
  output logic fs,
  output logic sd
);
  timeunit 1ns;
  timeprecision 1ns;
  // link clock, 80 ns, parked low when not enabled
  initial begin
    bclk = 1'h0;
    #13;
    forever begin
      #40;
      bclk = clk_en ? ~bclk : 1'h0;
    end
  end
  // frame sync low for the first bit, data moves on falling edges
  initial begin
    fs = FS_IDLE;
    sd = 1'h0;
  end
  always @(posedge send) begin
    for (int i = MSB; i >= 0; i--) begin
      @(negedge bclk);
      fs = (i == MSB) ? FS_ACTIVE : FS_IDLE;
      sd = word[i];
    end
    @(negedge bclk);
    sd = ~sd; // released line shows no stale bit
  end
endmodule
`default_nettype wire

// >>> test/ssp_pins_tb.sv
/* self-checking bench for ssp_pins with a serial peer model.
   assumes ssp_pkg, the design, the checker and ssp_peer are compiled first. */
`default_nettype none
module ssp_pins_tb
  import ssp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK, RST, CE, CLOCK_SOURCE_SELECT, FRAME_SYNC_DIRECTION, TX_VALID, TX_READY, link_on, peer_send;
  logic [WORD_BITS-1:0] TX_DATA, RX_DATA, peer_word;
  logic TX_BIT_CLOCK_IN, TX_BIT_CLOCK_OUT, TX_BIT_CLOCK_OE, TX_FRAME_SYNC_IN, TX_FRAME_SYNC_OUT, TX_FRAME_SYNC_OE;
  logic TX_SERIAL_OUT, TX_SERIAL_OE, RX_BIT_CLOCK, RX_FRAME_SYNC, RX_SERIAL_IN, RX_VALID, RX_CLOCK_LEVEL;
  logic TEST_RESET, EMULATOR_PIN_ZERO, OUTPUT_DISABLE_N;
  int n_fail = 0;
  int tests_run = 0;
  ssp_pins u_dut (.CLK, .RST, .CE, .CLOCK_SOURCE_SELECT, .FRAME_SYNC_DIRECTION, .TX_DATA, .TX_VALID, .TX_READY,
    .TX_BIT_CLOCK_IN, .TX_BIT_CLOCK_OUT, .TX_BIT_CLOCK_OE, .TX_FRAME_SYNC_IN, .TX_FRAME_SYNC_OUT, .TX_FRAME_SYNC_OE,
    .TX_SERIAL_OUT, .TX_SERIAL_OE, .RX_BIT_CLOCK, .RX_FRAME_SYNC, .RX_SERIAL_IN, .RX_DATA, .RX_VALID,
    .RX_CLOCK_LEVEL, .TEST_RESET, .EMULATOR_PIN_ZERO, .OUTPUT_DISABLE_N);
  ssp_peer u_peer (.clk_en(link_on), .send(peer_send), .word(peer_word), .bclk(RX_BIT_CLOCK),
    .fs(RX_FRAME_SYNC), .sd(RX_SERIAL_IN));
  // compare and count
  task automatic check(input string what, input logic [WORD_BITS-1:0] exp, input logic [WORD_BITS-1:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test;
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // wait n edges, then step off the last
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  // pins just after reset, clock source external
  task automatic t_reset;
    check("pin oes", 2'h0, {TX_BIT_CLOCK_OE, TX_FRAME_SYNC_OE});
    check("fs idle", FS_IDLE, TX_FRAME_SYNC_OUT);
  endtask
  // master word: internal clock, driven frame sync
  task automatic t_master_tx(input logic [WORD_BITS-1:0] w);
    int n;
    {CLOCK_SOURCE_SELECT, FRAME_SYNC_DIRECTION, TX_VALID} = 3'h7;
    TX_DATA = w;
    n = 0;
    #1;
    while (TX_READY !== 1'h1 && n < 20) begin
      tick(1);
      n++;
    end
    check("ready", 1'h1, TX_READY);
    tick(1);
    TX_VALID = 1'h0;
    check("tx oes", 2'h3, {TX_BIT_CLOCK_OE, TX_FRAME_SYNC_OE});
    for (int i = MSB; i >= 0; i--) begin
      check("tx bit", w[i], TX_SERIAL_OUT);
      check("tx fs", i != MSB, TX_FRAME_SYNC_OUT);
      check("bit clock", 1'h1, TX_BIT_CLOCK_OUT);
      tick(2);
    end
  endtask
  // slave word: the far side drives bit clock and frame sync
  task automatic t_slave_tx(input logic [WORD_BITS-1:0] w);
    {CLOCK_SOURCE_SELECT, FRAME_SYNC_DIRECTION, TX_VALID} = 3'h1;
    TX_DATA = w;
    tick(4);
    check("slave oes", 2'h0, {TX_BIT_CLOCK_OE, TX_FRAME_SYNC_OE});
    for (int i = MSB; i >= -1; i--) begin
      TX_BIT_CLOCK_IN = 1'h1;
      TX_FRAME_SYNC_IN = (i == MSB) ? FS_ACTIVE : FS_IDLE;
      tick(4);
      TX_VALID = 1'h0;
      if (i >= 0) begin
        check("slave bit", w[i], TX_SERIAL_OUT);
      end
      TX_BIT_CLOCK_IN = 1'h0;
      tick(4);
    end
  endtask
  // disable term, then each single term broken
  task automatic t_off;
    for (int k = 0; k < 4; k++) begin
      {TEST_RESET, EMULATOR_PIN_ZERO, OUTPUT_DISABLE_N} = (k == 0) ? 3'h2 : 3'h2 ^ (3'h1 << (k - 1));
      tick(5);
      check("oes", (k == 0) ? 3'h0 : 3'h7, {TX_SERIAL_OE, TX_FRAME_SYNC_OE, TX_BIT_CLOCK_OE});
    end
    {TEST_RESET, EMULATOR_PIN_ZERO, OUTPUT_DISABLE_N} = 3'h1;
  endtask
  // one received word, then the clock parks low
  task automatic t_rx(input logic [WORD_BITS-1:0] w);
    int n;
    link_on = 1'h1;
    tick(8);
    peer_word = w;
    peer_send = 1'h1;
    n = 0;
    while (RX_VALID !== 1'h1 && n < 60) begin
      tick(1);
      n++;
    end
    check("rx word", w, RX_DATA);
    peer_send = 1'h0;
    tick(2);
    link_on = 1'h0;
    tick(6);
    check("clock level", 1'h0, RX_CLOCK_LEVEL);
  endtask
  initial begin
    CLK = 1'h0;
    forever #20 CLK = ~CLK;
  end
  initial begin
    #100000;
    n_fail++;
    finish_test;
  end
  initial begin
    RST = 1'h1;
    CE = 1'h1;
    {CLOCK_SOURCE_SELECT, FRAME_SYNC_DIRECTION, TX_VALID, TX_BIT_CLOCK_IN, peer_send} = 5'h00;
    {TX_FRAME_SYNC_IN, link_on, TEST_RESET, EMULATOR_PIN_ZERO, OUTPUT_DISABLE_N} = 5'h19;
    TX_DATA = WORD_ZERO;
    peer_word = WORD_ZERO;
    tick(2);
    RST = 1'h0;
    tick(4); // link side still needs its synchronised reset edges
    link_on = 1'h0;
    t_reset;
    t_master_tx(16'h8001);
    t_master_tx(16'h7E5A);
    t_off;
    t_slave_tx(16'hB3C1);
    t_rx(16'h9C35);
    t_rx(16'h4A01);
    finish_test;
  end
endmodule
`default_nettype wire
